// File: pkg/iprs_pkg.sv
// Types shared by the input pin remap selector block
package iprs_pkg;
  typedef logic [5:0] iprs_field_t;
  typedef struct packed {
    iprs_field_t hi;
    iprs_field_t lo;
  } iprs_pair_s;
  typedef struct packed {
    logic sel;
    logic write;
    logic [7:0] addr;
  } iprs_req_s;
  typedef enum logic [1:0] {
    IPRS_IDLE = 2'b00,
    IPRS_WDATA = 2'b01
  } iprs_phase_e;
endpackage

// File: pkg/iprs_regs.svh
// Register offsets, field positions, reset values and timing for the input pin remap selectors
`ifndef IPRS_REGS_SVH
`define IPRS_REGS_SVH
`define IPRS_OFF_CAP34 8'h00
`define IPRS_OFF_CAP56 8'h04
`define IPRS_OFF_CAP78 8'h08
`define IPRS_OFF_FAULT 8'h0C
`define IPRS_OFF_CAP9 8'h10
`define IPRS_OFF_SER3 8'h14
`define IPRS_OFF_SER1 8'h18
`define IPRS_OFF_SER2 8'h1C
`define IPRS_OFF_LOCK 8'h20
`define IPRS_LO_POS 0
`define IPRS_HI_POS 8
`define IPRS_LOCK_POS 6
`define IPRS_FIELD_RST 6'h3F
`define IPRS_LOCK_RST 1'h0
`define IPRS_SYNC_STAGES 2
`endif

// File: rtl/iprs_route.sv
// One peripheral input selected from the synchronised pin vector
`timescale 1ns/1ps
`default_nettype none
module iprs_route import iprs_pkg::*; #(
  parameter int PINS = 48
) (
  input wire logic clk_sys, // System clock
  input wire logic rst, // Async reset, high
  input wire logic [PINS-1:0] pins, // Synchronised pins
  input wire iprs_field_t sel, // Pin number
  output logic dout // Peripheral input
);
  // Out of range pin numbers leave the input idle low
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      dout <= 1'b0;
    end else if (int'(sel) < PINS) begin
      dout <= pins[sel];
    end else begin
      dout <= 1'b0;
    end
  end
endmodule // iprs_route
`default_nettype wire

// File: rtl/iprs_sync.sv
// Two-stage synchroniser for the remappable pin levels
`timescale 1ns/1ps
`default_nettype none
module iprs_sync #(
  parameter int WIDTH = 8
) (
  input wire logic clk_sys, // System clock
  input wire logic rst, // Async reset, high
  input wire logic [WIDTH-1:0] din, // Raw pin levels
  output logic [WIDTH-1:0] dout // Synchronised levels
);
  logic [WIDTH-1:0] meta_q;
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      meta_q <= '0;
      dout <= '0;
    end else begin
      meta_q <= din;
      dout <= meta_q;
    end
  end
endmodule // iprs_sync
`default_nettype wire

// File: rtl/iprs_top.sv
// Input pin remap selectors with AHB-Lite register access
//
// Contract
// - Capture channels 3 and 4 follow the pins chosen by bits 5-0 and 13-8 of the first capture selector.
// - Capture channels 5 and 6 follow the pins chosen by bits 5-0 and 13-8 of the second capture selector.
// - Capture channels 7 and 8 follow the pins chosen by bits 5-0 and 13-8 of the third capture selector.
// - Capture channel 9 follows bits 13-8 of its selector and the low byte reads zero.
// - Fault inputs A and B follow bits 5-0 and 13-8 of the fault selector.
// - The third serial receive follows bits 13-8 of its selector; its low byte is absent.
// - The first serial receive and clear-to-send follow bits 5-0 and 13-8.
// - The second serial receive and clear-to-send follow bits 5-0 and 13-8.
// - Every unimplemented selector bit reads zero.
// - Every implemented selector bit is read/write and resets to one.
// - Selector writes take effect only while the lock bit is clear.
`timescale 1ns/1ps
`default_nettype none
`include "iprs_regs.svh"
module iprs_top import iprs_pkg::*; #(
  parameter int PINS = 48
) (
  input wire logic clk_sys, // System clock
  input wire logic rst, // Async reset, high
  input wire logic hsel, // Slave select
  input wire logic [31:0] haddr, // Byte address
  input wire logic [1:0] htrans, // Transfer type
  input wire logic hwrite, // Write access
  input wire logic [2:0] hsize, // Transfer size
  input wire logic [31:0] hwdata, // Write data
  input wire logic hready, // Bus ready
  output logic [31:0] hrdata, // Read data
  output logic hreadyout, // Slave ready
  output logic hresp, // Response
  input wire logic [PINS-1:0] pinIn, // Remappable pin levels
  output logic [8:2] captureIn, // Capture channels 3..9
  output logic faultAIn, // Compare fault A
  output logic faultBIn, // Compare fault B
  output logic serial1RxIn, // Serial 1 receive
  output logic serial1CtsIn, // Serial 1 clear to send
  output logic serial2RxIn, // Serial 2 receive
  output logic serial2CtsIn, // Serial 2 clear to send
  output logic serial3RxIn, // Serial 3 receive
  output logic remapLock // Lock bit state
);
  ////////////////////////////////////////////////////////////////
  iprs_pair_s cap34_q, cap56_q, cap78_q, fault_q, ser1_q, ser2_q;
  iprs_field_t cap9_q, ser3_q;
  logic lock_q;
  iprs_req_s req_q;
  iprs_phase_e phase_q;
  logic [PINS-1:0] pinSync;
  logic wrEn;
  logic [31:0] rdMux;
  logic rdWait;
  logic busAccept;

  assign remapLock = lock_q;
  assign busAccept = hready && hsel && htrans[1];

  // Writes need no wait; a read waits one cycle so hrdata leaves a flop
  assign rdWait = req_q.sel && !req_q.write && !hreadyout;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      hreadyout <= 1'b1;
    end else if (rdWait) begin
      hreadyout <= 1'b1;
    end else if (busAccept && !hwrite) begin
      hreadyout <= 1'b0;
    end
  end

  // No error response exists in this block
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      hresp <= 1'b0;
    end else begin
      hresp <= 1'b0;
    end
  end

  // Zero wait states on writes: address captured, data used next cycle
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      req_q <= '0;
      phase_q <= IPRS_IDLE;
    end else if (hready) begin
      req_q.sel <= hsel && htrans[1];
      req_q.write <= hwrite;
      req_q.addr <= haddr[7:0];
      phase_q <= (hsel && htrans[1] && hwrite) ? IPRS_WDATA : IPRS_IDLE;
    end
  end

  assign wrEn = req_q.sel && req_q.write && (phase_q == IPRS_WDATA);

  ////////////////////////////////////////////////////////////////
  // Lock writable at any time so software can release it
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      lock_q <= `IPRS_LOCK_RST;
    end else if (wrEn && req_q.addr == `IPRS_OFF_LOCK) begin
      lock_q <= hwdata[`IPRS_LOCK_POS];
    end
  end

  // Writes while locked are silently dropped
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      cap34_q <= {`IPRS_FIELD_RST, `IPRS_FIELD_RST};
      cap56_q <= {`IPRS_FIELD_RST, `IPRS_FIELD_RST};
      cap78_q <= {`IPRS_FIELD_RST, `IPRS_FIELD_RST};
      fault_q <= {`IPRS_FIELD_RST, `IPRS_FIELD_RST};
      ser1_q <= {`IPRS_FIELD_RST, `IPRS_FIELD_RST};
      ser2_q <= {`IPRS_FIELD_RST, `IPRS_FIELD_RST};
      cap9_q <= `IPRS_FIELD_RST;
      ser3_q <= `IPRS_FIELD_RST;
    end else if (wrEn && !lock_q) begin
      unique case (req_q.addr)
        `IPRS_OFF_CAP34: cap34_q <= {hwdata[`IPRS_HI_POS+:6], hwdata[`IPRS_LO_POS+:6]};
        `IPRS_OFF_CAP56: cap56_q <= {hwdata[`IPRS_HI_POS+:6], hwdata[`IPRS_LO_POS+:6]};
        `IPRS_OFF_CAP78: cap78_q <= {hwdata[`IPRS_HI_POS+:6], hwdata[`IPRS_LO_POS+:6]};
        `IPRS_OFF_FAULT: fault_q <= {hwdata[`IPRS_HI_POS+:6], hwdata[`IPRS_LO_POS+:6]};
        `IPRS_OFF_CAP9: cap9_q <= hwdata[`IPRS_HI_POS+:6];
        `IPRS_OFF_SER3: ser3_q <= hwdata[`IPRS_HI_POS+:6];
        `IPRS_OFF_SER1: ser1_q <= {hwdata[`IPRS_HI_POS+:6], hwdata[`IPRS_LO_POS+:6]};
        `IPRS_OFF_SER2: ser2_q <= {hwdata[`IPRS_HI_POS+:6], hwdata[`IPRS_LO_POS+:6]};
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////
  always_comb begin
    rdMux = 32'h0000_0000;
    unique case (req_q.addr)
      `IPRS_OFF_CAP34: rdMux = {18'h0, cap34_q.hi, 2'h0, cap34_q.lo};
      `IPRS_OFF_CAP56: rdMux = {18'h0, cap56_q.hi, 2'h0, cap56_q.lo};
      `IPRS_OFF_CAP78: rdMux = {18'h0, cap78_q.hi, 2'h0, cap78_q.lo};
      `IPRS_OFF_FAULT: rdMux = {18'h0, fault_q.hi, 2'h0, fault_q.lo};
      `IPRS_OFF_CAP9: rdMux = {18'h0, cap9_q, 8'h00};
      `IPRS_OFF_SER3: rdMux = {18'h0, ser3_q, 8'h00};
      `IPRS_OFF_SER1: rdMux = {18'h0, ser1_q.hi, 2'h0, ser1_q.lo};
      `IPRS_OFF_SER2: rdMux = {18'h0, ser2_q.hi, 2'h0, ser2_q.lo};
      `IPRS_OFF_LOCK: rdMux = {25'h0, lock_q, 6'h00};
      default: rdMux = 32'h0000_0000;
    endcase
  end

  // Read data loaded in the wait cycle, held for the one ready cycle
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      hrdata <= 32'h0000_0000;
    end else if (rdWait) begin
      hrdata <= rdMux;
    end else if (hready) begin
      hrdata <= 32'h0000_0000;
    end
  end

  ////////////////////////////////////////////////////////////////
  iprs_sync #(.WIDTH(PINS)) uSync (
    .clk_sys(clk_sys),
    .rst(rst),
    .din(pinIn),
    .dout(pinSync)
  );

  iprs_field_t selVec [0:13];
  logic [13:0] routed;
  assign selVec[0] = cap34_q.lo;
  assign selVec[1] = cap34_q.hi;
  assign selVec[2] = cap56_q.lo;
  assign selVec[3] = cap56_q.hi;
  assign selVec[4] = cap78_q.lo;
  assign selVec[5] = cap78_q.hi;
  assign selVec[6] = cap9_q;
  assign selVec[7] = fault_q.lo;
  assign selVec[8] = fault_q.hi;
  assign selVec[9] = ser1_q.lo;
  assign selVec[10] = ser1_q.hi;
  assign selVec[11] = ser2_q.lo;
  assign selVec[12] = ser2_q.hi;
  assign selVec[13] = ser3_q;

  for (genvar g = 0; g < 14; g++) begin : gRoute
    iprs_route #(.PINS(PINS)) uRoute (
      .clk_sys(clk_sys),
      .rst(rst),
      .pins(pinSync),
      .sel(selVec[g]),
      .dout(routed[g])
    );
  end

  assign captureIn = routed[6:0];
  assign faultAIn = routed[7];
  assign faultBIn = routed[8];
  assign serial1RxIn = routed[9];
  assign serial1CtsIn = routed[10];
  assign serial2RxIn = routed[11];
  assign serial2CtsIn = routed[12];
  assign serial3RxIn = routed[13];

  ////////////////////////////////////////////////////////////////
  sequence s_locked_write;
    wrEn && lock_q && req_q.addr == `IPRS_OFF_CAP34;
  endsequence

  sequence s_open_write(logic [7:0] off);
    wrEn && !lock_q && req_q.addr == off;
  endsequence

  // Index guard keeps the pin lookup inside the vector
  sequence s_sel_held(iprs_field_t s);
    int'(s) < PINS && $stable(s);
  endsequence

  sequence s_read_ready;
    req_q.sel && !req_q.write && hreadyout;
  endsequence

  // Lock and register writes
  a_locked_no_write: assert property (@(posedge clk_sys) disable iff (rst)
    s_locked_write |=> $stable(cap34_q)) else $error("locked write changed selector");
  a_locked_hold_all: assert property (@(posedge clk_sys) disable iff (rst)
    (wrEn && lock_q) |=> $stable({cap56_q, cap78_q, fault_q, ser1_q, ser2_q, cap9_q, ser3_q}))
    else $error("locked write changed a selector");
  a_lock_write: assert property (@(posedge clk_sys) disable iff (rst)
    (wrEn && req_q.addr == `IPRS_OFF_LOCK) |=> lock_q == $past(hwdata[`IPRS_LOCK_POS]))
    else $error("lock bit not written");
  a_open_write_cap34: assert property (@(posedge clk_sys) disable iff (rst)
    s_open_write(`IPRS_OFF_CAP34) |=> cap34_q.lo == $past(hwdata[5:0]))
    else $error("capture 3 field not written");
  a_cap4_write: assert property (@(posedge clk_sys) disable iff (rst)
    s_open_write(`IPRS_OFF_CAP34) |=> cap34_q.hi == $past(hwdata[13:8]))
    else $error("capture 4 field not written");
  a_cap5_write: assert property (@(posedge clk_sys) disable iff (rst)
    s_open_write(`IPRS_OFF_CAP56) |=> cap56_q.lo == $past(hwdata[5:0]))
    else $error("capture 5 field not written");
  a_cap56_write: assert property (@(posedge clk_sys) disable iff (rst)
    s_open_write(`IPRS_OFF_CAP56) |=> cap56_q.hi == $past(hwdata[13:8]))
    else $error("capture 6 field not written");
  a_cap78_write: assert property (@(posedge clk_sys) disable iff (rst)
    s_open_write(`IPRS_OFF_CAP78) |=> cap78_q.lo == $past(hwdata[5:0]))
    else $error("capture 7 field not written");
  a_cap8_write: assert property (@(posedge clk_sys) disable iff (rst)
    s_open_write(`IPRS_OFF_CAP78) |=> cap78_q.hi == $past(hwdata[13:8]))
    else $error("capture 8 field not written");
  a_fault_write: assert property (@(posedge clk_sys) disable iff (rst)
    s_open_write(`IPRS_OFF_FAULT) |=> fault_q.hi == $past(hwdata[13:8]))
    else $error("fault B field not written");
  a_fault_a_write: assert property (@(posedge clk_sys) disable iff (rst)
    s_open_write(`IPRS_OFF_FAULT) |=> fault_q.lo == $past(hwdata[5:0]))
    else $error("fault A field not written");
  a_cap9_write: assert property (@(posedge clk_sys) disable iff (rst)
    s_open_write(`IPRS_OFF_CAP9) |=> cap9_q == $past(hwdata[13:8]))
    else $error("capture 9 field not written");
  a_ser3_write: assert property (@(posedge clk_sys) disable iff (rst)
    s_open_write(`IPRS_OFF_SER3) |=> ser3_q == $past(hwdata[13:8]))
    else $error("serial 3 field not written");
  a_ser1_write: assert property (@(posedge clk_sys) disable iff (rst)
    s_open_write(`IPRS_OFF_SER1) |=> ser1_q == {$past(hwdata[13:8]), $past(hwdata[5:0])})
    else $error("serial 1 fields not written");
  a_ser2_write: assert property (@(posedge clk_sys) disable iff (rst)
    s_open_write(`IPRS_OFF_SER2) |=> ser2_q == {$past(hwdata[13:8]), $past(hwdata[5:0])})
    else $error("serial 2 fields not written");

  // Bus path: reads take one wait state, then data for one cycle; writes take none
  a_cap9_lowzero: assert property (@(posedge clk_sys) disable iff (rst)
    (req_q.sel && !req_q.write && hreadyout && req_q.addr == `IPRS_OFF_CAP9) |-> hrdata[7:0] == 8'h00)
    else $error("capture 9 low byte not zero");
  a_ser3_lowzero: assert property (@(posedge clk_sys) disable iff (rst)
    (req_q.sel && !req_q.write && hreadyout && req_q.addr == `IPRS_OFF_SER3) |-> hrdata[7:0] == 8'h00)
    else $error("serial 3 low byte not zero");
  a_unimpl_zero: assert property (@(posedge clk_sys) disable iff (rst)
    s_read_ready |-> (hrdata[31:14] == 18'h0 && hrdata[7:6] == 2'h0))
    else $error("unimplemented bits not zero");
  a_read_wait: assert property (@(posedge clk_sys) disable iff (rst)
    (busAccept && !hwrite) |=> !hreadyout ##1 hreadyout)
    else $error("read wait state wrong");
  a_write_nowait: assert property (@(posedge clk_sys) disable iff (rst)
    (busAccept && hwrite) |=> hreadyout)
    else $error("write was stalled");
  a_read_data: assert property (@(posedge clk_sys) disable iff (rst)
    (rdWait && req_q.addr == `IPRS_OFF_CAP34) |=> hrdata == {18'h0, $past(cap34_q.hi), 2'h0, $past(cap34_q.lo)})
    else $error("capture 3 and 4 read data wrong");
  a_resp_okay: assert property (@(posedge clk_sys) disable iff (rst)
    hresp == 1'b0) else $error("error response seen");

  // Reset state
  a_reset_ones: assert property (@(posedge clk_sys) $fell(rst) |-> cap56_q == 12'hFFF)
    else $error("selector not ones after reset");
  a_reset_all_ones: assert property (@(posedge clk_sys)
    $fell(rst) |-> {cap34_q, cap78_q, fault_q, ser1_q, ser2_q, cap9_q, ser3_q} == 72'hFF_FFFF_FFFF_FFFF_FFFF)
    else $error("selectors not all ones after reset");
  a_lock_reset: assert property (@(posedge clk_sys) $fell(rst) |-> lock_q == 1'b0)
    else $error("lock set after reset");

  // Routing: output follows the held pin one edge later
  a_cap3_route: assert property (@(posedge clk_sys) disable iff (rst)
    s_sel_held(cap34_q.lo) |=> captureIn[2] == $past(pinSync[cap34_q.lo]))
    else $error("capture 3 misrouted");
  a_cap4_route: assert property (@(posedge clk_sys) disable iff (rst)
    s_sel_held(cap34_q.hi) |=> captureIn[3] == $past(pinSync[cap34_q.hi]))
    else $error("capture 4 misrouted");
  a_cap5_route: assert property (@(posedge clk_sys) disable iff (rst)
    s_sel_held(cap56_q.lo) |=> captureIn[4] == $past(pinSync[cap56_q.lo]))
    else $error("capture 5 misrouted");
  a_cap6_route: assert property (@(posedge clk_sys) disable iff (rst)
    s_sel_held(cap56_q.hi) |=> captureIn[5] == $past(pinSync[cap56_q.hi]))
    else $error("capture 6 misrouted");
  a_cap7_route: assert property (@(posedge clk_sys) disable iff (rst)
    s_sel_held(cap78_q.lo) |=> captureIn[6] == $past(pinSync[cap78_q.lo]))
    else $error("capture 7 misrouted");
  a_cap8_route: assert property (@(posedge clk_sys) disable iff (rst)
    s_sel_held(cap78_q.hi) |=> captureIn[7] == $past(pinSync[cap78_q.hi]))
    else $error("capture 8 misrouted");
  a_cap9_route: assert property (@(posedge clk_sys) disable iff (rst)
    s_sel_held(cap9_q) |=> captureIn[8] == $past(pinSync[cap9_q]))
    else $error("capture 9 misrouted");
  a_fault_a_route: assert property (@(posedge clk_sys) disable iff (rst)
    s_sel_held(fault_q.lo) |=> faultAIn == $past(pinSync[fault_q.lo]))
    else $error("fault A misrouted");
  a_fault_b_route: assert property (@(posedge clk_sys) disable iff (rst)
    s_sel_held(fault_q.hi) |=> faultBIn == $past(pinSync[fault_q.hi]))
    else $error("fault B misrouted");
  a_ser1_route: assert property (@(posedge clk_sys) disable iff (rst)
    s_sel_held(ser1_q.lo) |=> serial1RxIn == $past(pinSync[ser1_q.lo]))
    else $error("serial 1 receive misrouted");
  a_ser1_cts_route: assert property (@(posedge clk_sys) disable iff (rst)
    s_sel_held(ser1_q.hi) |=> serial1CtsIn == $past(pinSync[ser1_q.hi]))
    else $error("serial 1 cts misrouted");
  a_ser2_rx_route: assert property (@(posedge clk_sys) disable iff (rst)
    s_sel_held(ser2_q.lo) |=> serial2RxIn == $past(pinSync[ser2_q.lo]))
    else $error("serial 2 receive misrouted");
  a_ser2_route: assert property (@(posedge clk_sys) disable iff (rst)
    s_sel_held(ser2_q.hi) |=> serial2CtsIn == $past(pinSync[ser2_q.hi]))
    else $error("serial 2 cts misrouted");
  a_ser3_route: assert property (@(posedge clk_sys) disable iff (rst)
    s_sel_held(ser3_q) |=> serial3RxIn == $past(pinSync[ser3_q]))
    else $error("serial 3 receive misrouted");

  // Out of range selections
  a_range_idle: assert property (@(posedge clk_sys) disable iff (rst)
    (int'(cap9_q) >= PINS) |=> captureIn[8] == 1'b0) else $error("out of range not low");
  a_range_ser3: assert property (@(posedge clk_sys) disable iff (rst)
    (int'(ser3_q) >= PINS) |=> serial3RxIn == 1'b0)
    else $error("serial 3 out of range not low");
endmodule // iprs_top
`default_nettype wire

// File: sim/input_pin_remap_selectors_tb_top.sv
// Testbench for the input pin remap selectors
`timescale 1ns/1ps
`default_nettype none
`include "iprs_regs.svh"
module input_pin_remap_selectors_tb_top import iprs_pkg::*;;
  typedef struct packed {
    logic [7:0] addr;
    iprs_field_t lo;
    iprs_field_t hi;
    logic hasLo;
  } iprs_row_s;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic hreadyout, hresp, faultAIn, faultBIn, remapLock;
  logic serial1RxIn, serial1CtsIn, serial2RxIn, serial2CtsIn, serial3RxIn;
  logic [8:2] captureIn;
  logic [47:0] level = 48'h0;
  logic [47:0] pat;
  logic [47:0] pinIn;
  logic [31:0] rd;
  logic [15:0] routed;
  iprs_row_s rows [8];
  int err_total = 0;
  int comparisons = 0;
  int cycles = 0;
  iprs_top #(.PINS(48)) iprs_top_i (.clk_sys(clk_sys), .rst(rst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .pinIn(pinIn), .captureIn(captureIn),
    .faultAIn(faultAIn), .faultBIn(faultBIn), .serial1RxIn(serial1RxIn), .serial1CtsIn(serial1CtsIn),
    .serial2RxIn(serial2RxIn), .serial2CtsIn(serial2CtsIn), .serial3RxIn(serial3RxIn),
    .remapLock(remapLock));
  iprs_pin_model #(.PINS(48)) iprs_pin_model_i (.level(level), .pins(pinIn));
  // Hi/lo output pairs in row order; absent low fields stand as 0
  assign routed = {serial2CtsIn, serial2RxIn, serial1CtsIn, serial1RxIn, serial3RxIn, 1'b0,
    captureIn[8], 1'b0, faultBIn, faultAIn, captureIn[7:2]};
  initial begin
    forever #4 clk_sys = ~clk_sys;
  end
  task automatic final_report();
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles > 3000) begin
      err_total++;
      final_report();
    end
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic bus(input logic we, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] r);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= we;
    haddr <= {24'h0, a};
    @(posedge clk_sys);
    while (hreadyout !== 1'b1) @(posedge clk_sys);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= we ? wd : 32'h0;
    @(posedge clk_sys);
    while (hreadyout !== 1'b1) @(posedge clk_sys);
    r = hrdata;
    check({31'h0, hresp}, 32'h0);
  endtask
  initial begin
    rows = '{'{`IPRS_OFF_CAP34, 6'h02, 6'h01, 1'b1}, '{`IPRS_OFF_CAP56, 6'h04, 6'h03, 1'b1},
      '{`IPRS_OFF_CAP78, 6'h06, 6'h05, 1'b1}, '{`IPRS_OFF_FAULT, 6'h08, 6'h07, 1'b1},
      '{`IPRS_OFF_CAP9, 6'h00, 6'h09, 1'b0}, '{`IPRS_OFF_SER3, 6'h00, 6'h0A, 1'b0},
      '{`IPRS_OFF_SER1, 6'h0C, 6'h0B, 1'b1}, '{`IPRS_OFF_SER2, 6'h0E, 6'h0D, 1'b1}};
    level <= 48'hFFFF_FFFF_FFFF;
    repeat (6) @(posedge clk_sys);
    rst <= 1'b0;
    repeat (4) @(posedge clk_sys);
    #1 check({16'h0, routed}, 32'h0);
    for (int i = 0; i < 8; i++) begin
      bus(1'b0, rows[i].addr, 32'h0, rd);
      check(rd, rows[i].hasLo ? 32'h3F3F : 32'h3F00);
    end
    $display("reset values done");
    for (int i = 0; i < 8; i++) begin
      bus(1'b1, rows[i].addr, {18'h3FFFF, rows[i].hi, 2'h3, rows[i].lo}, rd);
      bus(1'b0, rows[i].addr, 32'h0, rd);
      check(rd, {18'h0, rows[i].hi, 2'h0, rows[i].hasLo ? rows[i].lo : 6'h00});
    end
    for (int p = 0; p < 2; p++) begin
      pat = p ? 48'hFFFF_FFFF_A593 : 48'h0000_0000_5A6C;
      level <= pat;
      repeat (4) @(posedge clk_sys);
      #1;
      for (int i = 0; i < 8; i++) begin
        check({31'h0, routed[2*i+1]}, {31'h0, pat[rows[i].hi]});
        check({31'h0, routed[2*i]}, {31'h0, rows[i].hasLo & pat[rows[i].lo]});
      end
    end
    $display("table rows done");
    // Pin 8 feeds fault A: still old after two edges, new after the third
    level <= pat ^ 48'h100;
    repeat (2) @(posedge clk_sys);
    #1 check({31'h0, faultAIn}, {31'h0, pat[8]});
    @(posedge clk_sys);
    #1 check({31'h0, faultAIn}, {31'h0, ~pat[8]});
    bus(1'b1, `IPRS_OFF_LOCK, 32'h40, rd);
    bus(1'b1, `IPRS_OFF_CAP34, 32'h0, rd);
    bus(1'b0, `IPRS_OFF_CAP34, 32'h0, rd);
    check(rd, 32'h0102);
    check({31'h0, remapLock}, 32'h1);
    bus(1'b1, `IPRS_OFF_LOCK, 32'h0, rd);
    bus(1'b1, `IPRS_OFF_CAP34, 32'h2F30, rd);
    bus(1'b0, `IPRS_OFF_CAP34, 32'h0, rd);
    check(rd, 32'h2F30);
    $display("lock test done");
    level <= 48'hFFFF_FFFF_FFFF;
    repeat (4) @(posedge clk_sys);
    #1 check({30'h0, captureIn[3:2]}, 32'h2);
    bus(1'b1, 8'h24, 32'h3F3F, rd);
    bus(1'b0, 8'h24, 32'h0, rd);
    check(rd, 32'h0);
    rst <= 1'b1;
    repeat (2) @(posedge clk_sys);
    rst <= 1'b0;
    @(posedge clk_sys);
    bus(1'b0, `IPRS_OFF_CAP34, 32'h0, rd);
    check(rd, 32'h3F3F);
    $display("edge cases done");
    final_report();
  end
endmodule // input_pin_remap_selectors_tb_top
`default_nettype wire

// File: sim/iprs_pin_model.sv
// Pin-side model driving the remappable pin levels
`timescale 1ns/1ps
`default_nettype none
module iprs_pin_model #(
  parameter int PINS = 48
) (
  input wire logic [PINS-1:0] level, // Wanted levels
  output logic [PINS-1:0] pins // Pin levels
);
  // Plain driven levels, no clock here, so all latency seen belongs to the block
  assign pins = level;
endmodule // iprs_pin_model
`default_nettype wire
